// File: core/fpf_top.sv
// flash protection, fault status and command sequencer with avalon slave
//
// Implementation choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module fpf_top #(
  parameter int OP_DIV = 4,
  parameter int DERA_OP_CYCLES = 5025,
  parameter int DERA_BUS_CYCLES = 700
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // avalon-mm slave
  input wire logic [4:0] avm_address_i,
  input wire logic avm_read_i,
  input wire logic avm_write_i,
  input wire logic [3:0] avm_byteenable_i,
  input wire logic [31:0] avm_writedata_i,
  output logic [31:0] avm_readdata_o,
  output logic avm_waitrequest_o,
  // protection byte fetch during reset sequence
  input wire logic prot_valid_i,
  input wire logic [7:0] prot_byte_i,
  input wire logic prot_double_i,
  output logic prot_req_o,
  // array read fault report, same clock domain
  input wire logic arr_rd_valid_i,
  input wire logic arr_rd_single_i,
  input wire logic arr_rd_double_i,
  output logic cmd_busy_o,
  // interrupt
  output logic irq_o
);

  fpf_pkg::fpf_state_e state_reg;
  fpf_pkg::fpf_state_e state_next;
  logic wait_reg;
  logic [31:0] rdata_reg;
  logic irq_reg;
  logic [7:0] config_reg;
  logic [1:0] fault_reg;
  logic [1:0] mask_reg;
  fpf_pkg::fpf_prot_s prot_reg;
  logic command_complete_flag_reg;
  logic viol_reg;
  fpf_pkg::fpf_cmd_s cmd_reg;
  logic [8:0] result_reg;
  logic [23:0] cnt_reg;
  logic reject_reg;

  logic ack;
  logic wr_ack;
  logic [31:0] wmask;
  logic [31:0] wdata;
  logic launch;
  logic reject;
  logic [23:0] cycles;
  fpf_pkg::fpf_prot_s prot_wr;
  logic prot_ok;
  logic collide;
  logic sf_set;
  logic df_set;

  // request taken at the edge where waitrequest is seen low
  assign ack = (avm_read_i || avm_write_i) && !wait_reg;
  assign wr_ack = avm_write_i && !wait_reg;

  // lanes become one bit mask that every write path shares
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{avm_byteenable_i[i]}};
    end
  end

  assign wdata = avm_writedata_i & wmask;

  // bus ack: waitrequest drops for exactly one cycle per request
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wait_reg <= 1'b1;
    end else if ((avm_read_i || avm_write_i) && wait_reg) begin
      wait_reg <= 1'b0;
    end else begin
      wait_reg <= 1'b1;
    end
  end

  // read data is captured one cycle ahead and held through the ack
  // the fixed wait state buys a registered read path off the decode
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (avm_read_i && wait_reg) begin
      case (avm_address_i)
        fpf_pkg::OFS_CONFIG: rdata_reg <= {24'h000000, config_reg};
        fpf_pkg::OFS_FAULT: rdata_reg <= {30'h0, fault_reg};
        fpf_pkg::OFS_PROTECT: rdata_reg <= {24'h000000, prot_reg};
        fpf_pkg::OFS_STATUS: begin
          rdata_reg <= 32'h0000_0000;
          rdata_reg[fpf_pkg::STAT_COMMAND_COMPLETE_FLAG_BIT] <= command_complete_flag_reg;
          rdata_reg[fpf_pkg::STAT_VIOL_BIT] <= viol_reg;
        end
        fpf_pkg::OFS_CMD_OBJ: rdata_reg <= {2'h0, cmd_reg};
        fpf_pkg::OFS_RESULT: rdata_reg <= {23'h0, result_reg};
        fpf_pkg::OFS_INT_MASK: rdata_reg <= {30'h0, mask_reg};
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // configuration and interrupt mask
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      config_reg <= fpf_pkg::CONFIG_RST;
      mask_reg <= fpf_pkg::MASK_RST;
    end else if (wr_ack && avm_address_i == fpf_pkg::OFS_CONFIG) begin
      config_reg <= {7'h00, wdata[fpf_pkg::CFG_IGNORE_SF_BIT]};
    end else if (wr_ack && avm_address_i == fpf_pkg::OFS_INT_MASK) begin
      mask_reg <= wdata[1:0];
    end
  end

  // protected size index: 0 when disabled, else code plus one
  function automatic logic [2:0] lower_idx(input fpf_pkg::fpf_prot_s p);
    lower_idx = p.lower_disable ? 3'h0 : {1'b0, p.lower_protect_size_sel} + 3'h1;
  endfunction : lower_idx

  function automatic logic [2:0] upper_idx(input fpf_pkg::fpf_prot_s p);
    upper_idx = p.upper_disable ? 3'h0 : {1'b0, p.upper_size_sel} + 3'h1;
  endfunction : upper_idx

  // true when a program flash address lies in a protected area
  function automatic logic is_protected(input logic [17:0] a,
                                        input fpf_pkg::fpf_prot_s p);
    logic [17:0] lsize;
    logic [17:0] usize;
    lsize = fpf_pkg::LOWER_UNIT << p.lower_protect_size_sel;
    usize = fpf_pkg::UPPER_UNIT << p.upper_size_sel;
    is_protected = 1'b0;
    if (a >= fpf_pkg::PF_BASE) begin
      // open select clear overrides both region fields
      if (!p.open_sel) begin
        is_protected = 1'b1;
      end else if (!p.lower_disable && a < fpf_pkg::PF_BASE + lsize) begin
        is_protected = 1'b1;
      end else if (!p.upper_disable && a > fpf_pkg::PF_TOP - usize) begin
        is_protected = 1'b1;
      end
    end
  endfunction : is_protected

  // a write may only keep or enlarge the protected region
  assign prot_wr = fpf_pkg::fpf_prot_s'({wdata[7], 1'b0, wdata[5:0]});
  assign prot_ok = (prot_wr.open_sel <= prot_reg.open_sel) &&
                   (lower_idx(prot_wr) >= lower_idx(prot_reg)) &&
                   (upper_idx(prot_wr) >= upper_idx(prot_reg));

  // protection register: loaded after reset, then only tightened
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prot_reg <= fpf_pkg::PROTECT_RST;
    end else if (state_reg == fpf_pkg::ST_LOAD && prot_valid_i) begin
      if (prot_double_i) begin
        prot_reg <= fpf_pkg::PROTECT_FULL;
      end else begin
        prot_reg <= {prot_byte_i[7], 1'b0, prot_byte_i[5:0]};
      end
    end else if (wr_ack && avm_address_i == fpf_pkg::OFS_PROTECT &&
                 avm_byteenable_i[0] && prot_ok) begin
      prot_reg <= prot_wr;
    end
  end

  // fault flags from array reads
  // collision is any array read while a command counts, whatever the data
  assign collide = arr_rd_valid_i && state_reg == fpf_pkg::ST_RUN;
  assign df_set = arr_rd_valid_i && (collide || arr_rd_double_i);
  assign sf_set = arr_rd_valid_i && !config_reg[fpf_pkg::CFG_IGNORE_SF_BIT] &&
                  (collide || (arr_rd_single_i && !arr_rd_double_i));

  // set wins over a simultaneous write-one clear
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fault_reg <= fpf_pkg::FAULT_RST;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == fpf_pkg::FAULT_DF_BIT) ? df_set : sf_set) begin
          fault_reg[i] <= 1'b1;
        end else if (wr_ack && avm_address_i == fpf_pkg::OFS_FAULT &&
                     wdata[i]) begin
          fault_reg[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      // level interrupt one cycle behind the flags; software clears the cause
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(fault_reg & mask_reg);
    end
  end

  // command object is writable only while no command runs
  // per-lane merge lets code and address be written separately
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cmd_reg <= '0;
    end else if (wr_ack && avm_address_i == fpf_pkg::OFS_CMD_OBJ &&
                 command_complete_flag_reg) begin
      cmd_reg <= fpf_pkg::fpf_cmd_s'((cmd_reg & ~wmask[29:0]) | wdata[29:0]);
    end
  end

  // launch by writing one to the complete flag while it is set
  assign launch = wr_ack && avm_address_i == fpf_pkg::OFS_STATUS &&
                  wdata[fpf_pkg::STAT_COMMAND_COMPLETE_FLAG_BIT] && command_complete_flag_reg &&
                  state_reg == fpf_pkg::ST_IDLE;

  // rejection uses the protection seen at the launch edge
  always_comb begin
    reject = 1'b0;
    case (cmd_reg.code)
      fpf_pkg::CMD_PF_PROGRAM,
      fpf_pkg::CMD_PF_ERASE_SECTOR: begin
        reject = is_protected(cmd_reg.addr, prot_reg);
      end
      fpf_pkg::CMD_PF_ERASE_BLOCK: begin
        reject = !prot_reg.open_sel || lower_idx(prot_reg) != 3'h0 ||
                 upper_idx(prot_reg) != 3'h0;
      end
      default: reject = 1'b0;
    endcase
  end

  // cycle budget of the launched command, minus two for the count down
  // op clock figures scale by OP_DIV; bus cost uses the typical word figure
  always_comb begin
    logic [23:0] nw;
    logic [23:0] bc;
    logic [23:0] div;
    nw = {21'h0, cmd_reg.words};
    bc = {23'h0, cmd_reg.boundary};
    div = 24'(OP_DIV);
    case (cmd_reg.code)
      fpf_pkg::CMD_SET_MARGIN: begin
        cycles = fpf_pkg::MARGIN_BUS_CYC;
      end
      fpf_pkg::CMD_DF_VERIFY: begin
        cycles = fpf_pkg::VERIFY_BUS_CYC + nw;
      end
      fpf_pkg::CMD_DF_PROGRAM: begin
        cycles = 24'((fpf_pkg::DPGM_OP_BASE + fpf_pkg::DPGM_OP_WORD * nw +
                      fpf_pkg::DPGM_OP_ROW * bc) * div) +
                 24'(fpf_pkg::DPGM_BUS_BASE + fpf_pkg::DPGM_BUS_WORD * nw +
                     fpf_pkg::DPGM_BUS_ROW * bc);
      end
      fpf_pkg::CMD_DF_ERASE: begin
        cycles = 24'(24'(DERA_OP_CYCLES) * div) +
                 24'(DERA_BUS_CYCLES);
      end
      default: cycles = fpf_pkg::PF_CMD_CYC;
    endcase
  end

  // done lasts one cycle so results post together with the complete flag
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      fpf_pkg::ST_LOAD: begin
        if (prot_valid_i) begin
          state_next = fpf_pkg::ST_IDLE;
        end
      end
      fpf_pkg::ST_IDLE: begin
        if (launch) begin
          state_next = reject ? fpf_pkg::ST_DONE : fpf_pkg::ST_RUN;
        end
      end
      fpf_pkg::ST_RUN: begin
        if (cnt_reg == 24'h000000) begin
          state_next = fpf_pkg::ST_DONE;
        end
      end
      fpf_pkg::ST_DONE: state_next = fpf_pkg::ST_IDLE;
      default: state_next = fpf_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      // start in load so no command runs on an unknown protection
      state_reg <= fpf_pkg::ST_LOAD;
    end else begin
      state_reg <= state_next;
    end
  end

  // count down the budget; done state follows the last counted cycle
  // a budget under two cycles would wrap; every code here is longer
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_reg <= 24'h000000;
      reject_reg <= 1'b0;
    end else if (launch) begin
      cnt_reg <= cycles - 24'h000002;
      reject_reg <= reject;
    end else if (state_reg == fpf_pkg::ST_RUN && cnt_reg != 24'h000000) begin
      cnt_reg <= cnt_reg - 24'h000001;
    end
  end

  // complete flag low from launch until results are posted
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      command_complete_flag_reg <= 1'b0;
      result_reg <= 9'h000;
    end else if (state_reg == fpf_pkg::ST_LOAD) begin
      command_complete_flag_reg <= prot_valid_i;
    end else if (launch) begin
      command_complete_flag_reg <= 1'b0;
    end else if (state_reg == fpf_pkg::ST_DONE) begin
      command_complete_flag_reg <= 1'b1;
      result_reg <= {reject_reg, cmd_reg.code};
    end
  end

  // violation flag: set on rejection, set wins over write-one clear
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      viol_reg <= 1'b0;
    end else if (launch && reject) begin
      viol_reg <= 1'b1;
    end else if (wr_ack && avm_address_i == fpf_pkg::OFS_STATUS &&
                 wdata[fpf_pkg::STAT_VIOL_BIT]) begin
      viol_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      // built from state_next so both outputs line up with state_reg after the first edge out of reset
      cmd_busy_o <= 1'b0;
      prot_req_o <= 1'b0;
    end else begin
      cmd_busy_o <= state_next == fpf_pkg::ST_RUN;
      prot_req_o <= state_next == fpf_pkg::ST_LOAD;
    end
  end

  assign avm_readdata_o = rdata_reg;
  assign avm_waitrequest_o = wait_reg;
  assign irq_o = irq_reg;

endmodule : fpf_top
`default_nettype wire

// File: core/fpf_pkg.sv
// constants, field layouts and state types of the flash protection and fault block
package fpf_pkg;

  // register byte offsets on the avalon slave
  localparam logic [4:0] OFS_CONFIG = 5'h00;
  localparam logic [4:0] OFS_FAULT = 5'h04;
  localparam logic [4:0] OFS_PROTECT = 5'h08;
  localparam logic [4:0] OFS_STATUS = 5'h0C;
  localparam logic [4:0] OFS_CMD_OBJ = 5'h10;
  localparam logic [4:0] OFS_RESULT = 5'h14;
  localparam logic [4:0] OFS_INT_MASK = 5'h18;

  // field positions
  localparam int CFG_IGNORE_SF_BIT = 0;
  localparam int FAULT_SF_BIT = 0;
  localparam int FAULT_DF_BIT = 1;
  localparam int STAT_VIOL_BIT = 4;
  localparam int STAT_COMMAND_COMPLETE_FLAG_BIT = 7;
  localparam int RES_REJECT_BIT = 8;

  // reset values
  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [1:0] FAULT_RST = 2'h0;
  localparam logic [1:0] MASK_RST = 2'h0;
  localparam logic [7:0] PROTECT_RST = 8'h00;
  localparam logic [7:0] PROTECT_FULL = 8'h3F;

  // program flash map, 18-bit global addresses
  localparam logic [17:0] PF_BASE = 18'h38000;
  localparam logic [17:0] PF_TOP = 18'h3FFFF;
  localparam logic [17:0] PROT_BYTE_ADDR = 18'h3FF0C;
  localparam logic [17:0] LOWER_UNIT = 18'h00400;
  localparam logic [17:0] UPPER_UNIT = 18'h00800;

  // command codes
  localparam logic [7:0] CMD_PF_PROGRAM = 8'h06;
  localparam logic [7:0] CMD_PF_ERASE_BLOCK = 8'h09;
  localparam logic [7:0] CMD_PF_ERASE_SECTOR = 8'h0A;
  localparam logic [7:0] CMD_SET_MARGIN = 8'h0E;
  localparam logic [7:0] CMD_DF_VERIFY = 8'h10;
  localparam logic [7:0] CMD_DF_PROGRAM = 8'h11;
  localparam logic [7:0] CMD_DF_ERASE = 8'h12;

  // cycle budgets, memory bus clock unless noted as op clock
  localparam logic [23:0] MARGIN_BUS_CYC = 24'd350;
  localparam logic [23:0] VERIFY_BUS_CYC = 24'd450;
  localparam logic [23:0] DPGM_OP_BASE = 24'd14;
  localparam logic [23:0] DPGM_OP_WORD = 24'd54;
  localparam logic [23:0] DPGM_OP_ROW = 24'd14;
  localparam logic [23:0] DPGM_BUS_BASE = 24'd500;
  localparam logic [23:0] DPGM_BUS_WORD = 24'd525;
  localparam logic [23:0] DPGM_BUS_WORD_MAX = 24'd750;
  localparam logic [23:0] DPGM_BUS_ROW = 24'd100;
  localparam logic [23:0] DERA_OP_CYC = 24'd5025;
  localparam logic [23:0] DERA_OP_CYC_MAX = 24'd20100;
  localparam logic [23:0] DERA_BUS_CYC = 24'd700;
  localparam logic [23:0] DERA_BUS_CYC_MAX = 24'd3400;
  localparam logic [23:0] PF_CMD_CYC = 24'd64;

  // protection register layout
  typedef struct packed {
    logic open_sel;
    logic rsvd;
    logic upper_disable;
    logic [1:0] upper_size_sel;
    logic lower_disable;
    logic [1:0] lower_protect_size_sel;
  } fpf_prot_s;

  // command object layout
  typedef struct packed {
    logic [17:0] addr;
    logic boundary;
    logic [2:0] words;
    logic [7:0] code;
  } fpf_cmd_s;

  typedef enum logic [1:0] {
    ST_LOAD = 2'h0,
    ST_IDLE = 2'h1,
    ST_RUN = 2'h3,
    ST_DONE = 2'h2
  } fpf_state_e;

endpackage : fpf_pkg

// File: testbench/fpf_assertions.sv
// port-level assertion checker for the flash protection and fault block
`timescale 1ns/1ps
`default_nettype none
module fpf_assertions #(
  parameter int OP_DIV = 4,
  parameter int DERA_OP_CYCLES = 5025,
  parameter int DERA_BUS_CYCLES = 700
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // register bus
  input wire logic [4:0] avm_address_i,
  input wire logic avm_write_i,
  input wire logic [3:0] avm_byteenable_i,
  input wire logic [31:0] avm_writedata_i,
  input wire logic avm_waitrequest_o,
  // protection fetch and array reads
  input wire logic prot_valid_i,
  input wire logic prot_req_o,
  input wire logic arr_rd_valid_i,
  input wire logic arr_rd_single_i,
  input wire logic arr_rd_double_i,
  input wire logic cmd_busy_o,
  input wire logic irq_o
);
  logic ack, ign_q, clr, clr_q;
  logic [1:0] msk_q;
  logic [23:0] cnt_q, exp_len, w, b;
  fpf_pkg::fpf_cmd_s cmd_q;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  assign ack = avm_write_i && !avm_waitrequest_o && avm_byteenable_i[0];
  // a mask write may drop the interrupt as legally as a clear
  assign clr = ack && ((avm_address_i == fpf_pkg::OFS_FAULT &&
    |avm_writedata_i[1:0]) || avm_address_i == fpf_pkg::OFS_INT_MASK);
  assign w = 24'(cmd_q.words);
  assign b = 24'(cmd_q.boundary);
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ign_q <= 1'b0;
      msk_q <= 2'h0;
      clr_q <= 1'b0;
    end else begin
      clr_q <= clr;
      if (ack && avm_address_i == fpf_pkg::OFS_CONFIG)
        ign_q <= avm_writedata_i[0];
      if (ack && avm_address_i == fpf_pkg::OFS_INT_MASK)
        msk_q <= avm_writedata_i[1:0];
    end
  end
  // command object only moves while idle, so it names the running command
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cmd_q <= '0;
      cnt_q <= 24'h0;
    end else begin
      cnt_q <= cmd_busy_o ? cnt_q + 24'h1 : 24'h0;
      if (ack && !cmd_busy_o && avm_address_i == fpf_pkg::OFS_CMD_OBJ)
        cmd_q <= avm_writedata_i[29:0];
    end
  end
  always_comb begin
    case (cmd_q.code)
      fpf_pkg::CMD_SET_MARGIN: exp_len = fpf_pkg::MARGIN_BUS_CYC;
      fpf_pkg::CMD_DF_VERIFY: exp_len = fpf_pkg::VERIFY_BUS_CYC + w;
      fpf_pkg::CMD_DF_PROGRAM: exp_len = (fpf_pkg::DPGM_OP_BASE +
        fpf_pkg::DPGM_OP_WORD * w + fpf_pkg::DPGM_OP_ROW * b) * 24'(OP_DIV) +
        fpf_pkg::DPGM_BUS_BASE + fpf_pkg::DPGM_BUS_WORD * w + fpf_pkg::DPGM_BUS_ROW * b;
      fpf_pkg::CMD_DF_ERASE: exp_len = 24'(DERA_OP_CYCLES * OP_DIV + DERA_BUS_CYCLES);
      default: exp_len = fpf_pkg::PF_CMD_CYC;
    endcase
  end
  a_load_req_drop: assert property (
    prot_req_o && prot_valid_i |-> ##[1:2] !prot_req_o)
    else $error("protection fetch request stays up");
  a_double_flag_irq: assert property (
    arr_rd_valid_i && (arr_rd_double_i || cmd_busy_o) && msk_q[1]
    |-> ##2 irq_o)
    else $error("double fault raised no interrupt");
  a_single_flag_irq: assert property (
    arr_rd_valid_i && arr_rd_single_i && !arr_rd_double_i && !ign_q &&
    msk_q[0] |-> ##2 irq_o)
    else $error("single fault raised no interrupt");
  a_flag_sticky: assert property (
    irq_o && !clr && !clr_q |=> irq_o)
    else $error("interrupt dropped without a clear");
  a_collision_single: assert property (
    arr_rd_valid_i && cmd_busy_o && !ign_q && msk_q[0] |-> ##2 irq_o)
    else $error("collision did not set single flag");
  a_margin_time: assert property (
    $fell(cmd_busy_o) && cmd_q.code == fpf_pkg::CMD_SET_MARGIN
    |-> cnt_q == exp_len - 24'h1)
    else $error("margin command length wrong");
  a_verify_time: assert property (
    $fell(cmd_busy_o) && cmd_q.code == fpf_pkg::CMD_DF_VERIFY
    |-> cnt_q == exp_len - 24'h1)
    else $error("verify command length wrong");
  a_program_time: assert property (
    $fell(cmd_busy_o) && cmd_q.code == fpf_pkg::CMD_DF_PROGRAM
    |-> cnt_q == exp_len - 24'h1)
    else $error("program command length wrong");
  a_erase_time: assert property (
    $fell(cmd_busy_o) && cmd_q.code == fpf_pkg::CMD_DF_ERASE
    |-> cnt_q == exp_len - 24'h1)
    else $error("erase command length wrong");
endmodule : fpf_assertions
bind fpf_top fpf_assertions #(.OP_DIV(OP_DIV), .DERA_OP_CYCLES(DERA_OP_CYCLES),
  .DERA_BUS_CYCLES(DERA_BUS_CYCLES)) u_chk (.sys_clk_i(sys_clk_i),
  .reset_n_i(reset_n_i), .avm_address_i(avm_address_i), .avm_write_i(avm_write_i),
  .avm_byteenable_i(avm_byteenable_i), .avm_writedata_i(avm_writedata_i),
  .avm_waitrequest_o(avm_waitrequest_o), .prot_valid_i(prot_valid_i),
  .prot_req_o(prot_req_o), .arr_rd_valid_i(arr_rd_valid_i),
  .arr_rd_single_i(arr_rd_single_i), .arr_rd_double_i(arr_rd_double_i),
  .cmd_busy_o(cmd_busy_o), .irq_o(irq_o));
`default_nettype wire

// File: testbench/tb.sv
// self-checking testbench for the flash protection and fault block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
  $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module tb;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [4:0] avm_address_i = 5'h00;
  logic avm_read_i = 1'b0;
  logic avm_write_i = 1'b0;
  logic [3:0] avm_byteenable_i = 4'hF;
  logic [31:0] avm_writedata_i = 32'h0;
  logic prot_valid_i = 1'b0;
  logic [7:0] prot_byte_i = 8'h00;
  logic prot_double_i = 1'b0;
  logic arr_rd_valid_i = 1'b0;
  logic arr_rd_single_i = 1'b0;
  logic arr_rd_double_i = 1'b0;
  logic [31:0] avm_readdata_o, rdata;
  logic avm_waitrequest_o, prot_req_o, cmd_busy_o, irq_o;
  int errors = 0;
  int checks = 0;
  always #12.5 sys_clk_i = ~sys_clk_i;
  // short erase counts keep the run brief
  fpf_top #(.DERA_OP_CYCLES(20), .DERA_BUS_CYCLES(10)) uut (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .avm_address_i(avm_address_i),
    .avm_read_i(avm_read_i), .avm_write_i(avm_write_i),
    .avm_byteenable_i(avm_byteenable_i), .avm_writedata_i(avm_writedata_i),
    .avm_readdata_o(avm_readdata_o), .avm_waitrequest_o(avm_waitrequest_o),
    .prot_valid_i(prot_valid_i), .prot_byte_i(prot_byte_i),
    .prot_double_i(prot_double_i), .prot_req_o(prot_req_o),
    .arr_rd_valid_i(arr_rd_valid_i), .arr_rd_single_i(arr_rd_single_i),
    .arr_rd_double_i(arr_rd_double_i), .cmd_busy_o(cmd_busy_o), .irq_o(irq_o));
  task automatic summarize;
    $display("mismatches %0d comparisons %0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize
  task automatic bound(input logic ok);
    if (!ok) begin
      errors++;
      summarize();
    end
  endtask : bound
  // one idle edge first so a released strobe is never re-driven in one step
  task automatic acc(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    avm_address_i <= a;
    avm_writedata_i <= d;
    avm_write_i <= wr;
    avm_read_i <= !wr;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (avm_waitrequest_o !== 1'b0 && n < 20);
    bound(avm_waitrequest_o === 1'b0);
    rdata = avm_readdata_o;
    avm_write_i <= 1'b0;
    avm_read_i <= 1'b0;
  endtask : acc
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [4:0] a);
    acc(1'b0, a, 32'h0);
  endtask : rd
  task automatic wait_done;
    int n;
    n = 0;
    do begin
      rd(fpf_pkg::OFS_STATUS);
      n++;
    end while (rdata[7] !== 1'b1 && n < 3000);
    bound(rdata[7] === 1'b1);
  endtask : wait_done
  task automatic run_cmd(input logic [7:0] c, input logic [2:0] w,
      input logic bnd, input logic [17:0] a, input logic v);
    wr(fpf_pkg::OFS_CMD_OBJ, {2'h0, a, bnd, w, c});
    wr(fpf_pkg::OFS_STATUS, 32'h80);
    wait_done();
    rd(fpf_pkg::OFS_STATUS);
    `CHK("violation", v, rdata[4])
    rd(fpf_pkg::OFS_RESULT);
    `CHK("result", {v, c}, rdata[8:0])
    wr(fpf_pkg::OFS_STATUS, 32'h10);
  endtask : run_cmd
  task automatic boot(input logic [7:0] pb, input logic dbl);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    reset_n_i <= 1'b0;
    repeat (8) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (prot_req_o !== 1'b1 && n < 20);
    bound(prot_req_o === 1'b1);
    prot_byte_i <= pb;
    prot_double_i <= dbl;
    prot_valid_i <= 1'b1;
    @(posedge sys_clk_i);
    prot_valid_i <= 1'b0;
  endtask : boot
  task automatic pulse(input logic s, input logic d);
    @(posedge sys_clk_i);
    arr_rd_valid_i <= 1'b1;
    arr_rd_single_i <= s;
    arr_rd_double_i <= d;
    @(posedge sys_clk_i);
    arr_rd_valid_i <= 1'b0;
  endtask : pulse
  task automatic fault(input logic [1:0] e);
    rd(fpf_pkg::OFS_FAULT);
    `CHK("fault", e, rdata[1:0])
  endtask : fault
  task automatic prot(input logic [7:0] d, input logic [7:0] e);
    wr(fpf_pkg::OFS_PROTECT, {24'h0, d});
    rd(fpf_pkg::OFS_PROTECT);
    `CHK("protect", e, rdata[7:0])
  endtask : prot
  initial begin
    logic [17:0] lim;
    boot(8'h11, 1'b1);
    rd(fpf_pkg::OFS_PROTECT);
    `CHK("protect", fpf_pkg::PROTECT_FULL, rdata[7:0])
    run_cmd(fpf_pkg::CMD_PF_PROGRAM, 3'd1, 1'b0,
      fpf_pkg::PF_BASE, 1'b1);
    boot(8'hE4, 1'b0);
    rd(fpf_pkg::OFS_PROTECT);
    `CHK("protect", 8'hA4, rdata[7:0])
    run_cmd(fpf_pkg::CMD_PF_ERASE_BLOCK, 3'd0, 1'b0,
      fpf_pkg::PF_BASE, 1'b0);
    for (int s = 0; s < 4; s++) begin
      lim = fpf_pkg::PF_BASE + (fpf_pkg::LOWER_UNIT << s);
      prot(8'hA0 | 8'(s), 8'hA0 | 8'(s));
      run_cmd(fpf_pkg::CMD_PF_ERASE_SECTOR, 3'd0, 1'b0,
        lim - 18'h2, 1'b1);
      run_cmd(fpf_pkg::CMD_PF_PROGRAM, 3'd1, 1'b0,
        lim, 1'b0);
    end
    // upper sector guards the stored protection byte
    prot(8'h83, 8'h83);
    run_cmd(fpf_pkg::CMD_PF_PROGRAM, 3'd1, 1'b0,
      fpf_pkg::PROT_BYTE_ADDR, 1'b1);
    run_cmd(fpf_pkg::CMD_PF_PROGRAM, 3'd1, 1'b0,
      fpf_pkg::PF_TOP - fpf_pkg::UPPER_UNIT, 1'b0);
    prot(8'hA1, 8'h83);
    run_cmd(fpf_pkg::CMD_PF_ERASE_BLOCK, 3'd0, 1'b0,
      fpf_pkg::PF_TOP, 1'b1);
    prot(8'h03, 8'h03);
    prot(8'hA3, 8'h03);
    run_cmd(fpf_pkg::CMD_PF_PROGRAM, 3'd1, 1'b0,
      fpf_pkg::PF_BASE + 18'h4000, 1'b1);
    run_cmd(fpf_pkg::CMD_SET_MARGIN, 3'd0, 1'b0, 18'h0, 1'b0);
    run_cmd(fpf_pkg::CMD_DF_VERIFY, 3'd5, 1'b0, 18'h0, 1'b0);
    run_cmd(fpf_pkg::CMD_DF_PROGRAM, 3'd4, 1'b1, 18'h0, 1'b0);
    run_cmd(fpf_pkg::CMD_DF_PROGRAM, 3'd1, 1'b0, 18'h0, 1'b0);
    run_cmd(fpf_pkg::CMD_DF_ERASE, 3'd0, 1'b0, 18'h0, 1'b0);
    wr(fpf_pkg::OFS_INT_MASK, 32'h3);
    pulse(1'b1, 1'b0);
    fault(2'h1);
    `CHK("irq", 1'b1, irq_o)
    wr(fpf_pkg::OFS_FAULT, 32'h0);
    fault(2'h1);
    wr(fpf_pkg::OFS_FAULT, 32'h1);
    fault(2'h0);
    `CHK("irq", 1'b0, irq_o)
    pulse(1'b1, 1'b1);
    fault(2'h2);
    wr(fpf_pkg::OFS_FAULT, 32'h3);
    wr(fpf_pkg::OFS_CMD_OBJ, {24'h0, fpf_pkg::CMD_SET_MARGIN});
    wr(fpf_pkg::OFS_STATUS, 32'h80);
    pulse(1'b0, 1'b0);
    wait_done();
    fault(2'h3);
    wr(fpf_pkg::OFS_FAULT, 32'h3);
    wr(fpf_pkg::OFS_CONFIG, 32'h1);
    pulse(1'b1, 1'b0);
    fault(2'h0);
    wr(fpf_pkg::OFS_INT_MASK, 32'h0);
    pulse(1'b0, 1'b1);
    fault(2'h2);
    `CHK("irq", 1'b0, irq_o)
    summarize();
  end
endmodule : tb
`default_nettype wire
